// File: core/rfiq_pkg.sv
// Constants shared by the radio interrupt and queue port block.
// Assumes an 8-bit special-function register bus on the CPU side.
package rfiq_pkg;

	// Special-function register addresses.
	localparam logic [7:0] ADDR_MASK  = 8'h91;
	localparam logic [7:0] ADDR_DATA  = 8'hD9;
	localparam logic [7:0] ADDR_FLAGS = 8'hE9;

	// Values after reset.
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Source flag and mask bit positions.
	localparam int BIT_REG_ON    = 7;
	localparam int BIT_TX_DONE   = 6;
	localparam int BIT_RX_THR    = 5;
	localparam int BIT_FRAME     = 4;
	localparam int BIT_CHAN_CLR  = 3;
	localparam int BIT_SEQ_WAIT  = 2;
	localparam int BIT_SEQ_HALT  = 1;
	localparam int BIT_SEQ_INSTR = 0;

	// CPU vector numbers of the two requests.
	localparam int VEC_ERROR = 0;
	localparam int VEC_EVENT = 12;

	// Sizes of data, sources and queues.
	localparam int DATA_W      = 8;
	localparam int NUM_SRC     = 8;
	localparam int THR_W       = 7;
	localparam int QUEUE_DEPTH = 128;
	localparam int STAGE_DEPTH = 4;
	localparam int QCNT_W      = 8;

endpackage : rfiq_pkg

// File: core/rfiq_fifo.sv
// Synchronous FIFO with flush, valid and ready on both sides.
// Assumes one clock; flush empties it in one cycle and wins over a push.
`timescale 1ns/1ps
`default_nettype none
module rfiq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Empties the FIFO.
	input  wire logic             flush,
	// Filling side.
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data,
	// Number of words held.
	output var  logic [CW-1:0]    count
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];      // Storage words.
	logic [PW-1:0]    wr_ptr;           // Next slot to write.
	logic [PW-1:0]    rd_ptr;           // Oldest word.
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [CW-1:0]    next_count;
	logic             next_in_ready;
	logic             next_out_valid;
	logic             push;             // Word taken this cycle.
	logic             pop;              // Word given this cycle.

	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	// Pointer, count and registered full and empty flags.
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (flush) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end else begin
			if (push) begin
				next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			end
			if (push && !pop) begin
				next_count = count + CW'(1);
			end else if (pop && !push) begin
				next_count = count - CW'(1);
			end
		end
		next_in_ready  = (next_count != CW'(DEPTH));
		next_out_valid = (next_count != '0);
	end

	// Registers the control state.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			in_ready  <= next_in_ready;
			out_valid <= next_out_valid;
		end
	end

	// Storage needs no reset; a flushed word is never read.
	always_ff @(posedge sys_clk) begin
		if (push && !flush) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule : rfiq_fifo
`default_nettype wire

// File: core/rfiq_top.sv
// Radio event flags, masks, CPU requests and the queue data port.
// Assumes the CPU interrupt controller supplies vector enables and
// clears; radio conditions arrive as levels synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rfiq_top (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Special-function register bus.
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output var  logic [7:0] sfr_rdata,
	// CPU interrupt controller bits for the two vectors.
	input  wire logic       error_vector_enable,
	input  wire logic       event_vector_enable,
	input  wire logic       error_pending_clear,
	input  wire logic       event_pending_clear,
	output var  logic       error_vector_pending,
	output var  logic       event_vector_pending,
	output var  logic       radio_error_request,
	output var  logic       radio_event_request,
	// Radio event conditions, all levels.
	input  wire logic       regulator_on,
	input  wire logic       transmit_done,
	input  wire logic       ack_sent,
	input  wire logic       ack_source_select,
	input  wire logic       frame_start,
	input  wire logic       channel_clear,
	input  wire logic       sequencer_wait,
	input  wire logic       sequencer_halt,
	input  wire logic       sequencer_instr,
	input  wire logic       transmit_underflow,
	// Receive threshold and queue status.
	input  wire logic [6:0] receive_threshold_level,
	output var  logic       receive_data_present,
	output var  logic       receive_threshold_status,
	// Command strobes.
	input  wire logic       transmit_flush_strobe,
	input  wire logic       receive_flush_strobe,
	// Bytes from the receiver.
	input  wire logic       rx_byte_valid,
	output var  logic       rx_byte_ready,
	input  wire logic [7:0] rx_byte,
	// Bytes to the transmitter.
	output var  logic       tx_byte_valid,
	input  wire logic       tx_byte_ready,
	output var  logic [7:0] tx_byte
);

	// Tells whether a bus address selects a given register.
	// One form for all four decodes keeps them from drifting apart.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction : hit

	logic [7:0] radio_source_mask_reg;  // Per-source enables.
	logic [7:0] radio_source_flag_reg;  // Sticky source flags.
	logic [7:0] next_mask;
	logic [7:0] next_flags;
	logic [7:0] next_rdata;
	logic [7:0] cond_now;               // Source conditions now.
	logic [7:0] cond_prev;              // Conditions one cycle ago.
	logic       flag_wr;                // Bus write to the flags.
	logic       mask_wr;                // Bus write to the mask.
	logic       data_wr;                // Bus write to the data port.
	logic       data_rd;                // Bus read of the data port.
	logic       event_req;              // Any enabled flag set.
	logic       rx_overflow;            // Sticky until receive flush.
	logic       next_overflow;
	logic       overflow_event;         // Byte lost this cycle.
	logic       error_event;
	logic       next_err_pend;
	logic       next_evt_pend;
	logic       next_thr_status;
	logic       next_present;

	// Staging, receive and transmit queue wires.
	logic       stg_out_valid;
	logic       stg_out_ready;
	logic [7:0] stg_out_data;
	logic       rxq_in_ready;
	logic       rxq_out_valid;
	logic [7:0] rxq_out_data;
	logic [7:0] rxq_count;
	logic [7:0] txq_count;

	assign flag_wr = sfr_wr & hit(sfr_addr, rfiq_pkg::ADDR_FLAGS);
	assign mask_wr = sfr_wr & hit(sfr_addr, rfiq_pkg::ADDR_MASK);
	assign data_wr = sfr_wr & hit(sfr_addr, rfiq_pkg::ADDR_DATA);
	assign data_rd = sfr_rd & hit(sfr_addr, rfiq_pkg::ADDR_DATA);

	// Four-byte staging buffer; its ready back-pressures the receiver.
	// The receiver sees ready fall only when all four places are taken.
	rfiq_fifo #(
		.WIDTH (rfiq_pkg::DATA_W),
		.DEPTH (rfiq_pkg::STAGE_DEPTH)
	) u_stage (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (receive_flush_strobe),
		.in_valid  (rx_byte_valid),
		.in_ready  (rx_byte_ready),
		.in_data   (rx_byte),
		.out_valid (stg_out_valid),
		.out_ready (stg_out_ready),
		.out_data  (stg_out_data),
		.count     ()
	);

	// While overflowed, staged bytes are thrown away, not queued.
	assign stg_out_ready = rxq_in_ready | rx_overflow;

	// Receive queue of 128 bytes, popped by data port reads.
	// Bytes already queued stay readable after an overflow.
	rfiq_fifo #(
		.WIDTH (rfiq_pkg::DATA_W),
		.DEPTH (rfiq_pkg::QUEUE_DEPTH)
	) u_rx_queue (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (receive_flush_strobe),
		.in_valid  (stg_out_valid & ~rx_overflow),
		.in_ready  (rxq_in_ready),
		.in_data   (stg_out_data),
		.out_valid (rxq_out_valid),
		.out_ready (data_rd),
		.out_data  (rxq_out_data),
		.count     (rxq_count)
	);

	// Transmit queue of 128 bytes; a write when full is dropped.
	// Nothing reports the drop, so software must pace its writes.
	rfiq_fifo #(
		.WIDTH (rfiq_pkg::DATA_W),
		.DEPTH (rfiq_pkg::QUEUE_DEPTH)
	) u_tx_queue (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (transmit_flush_strobe),
		.in_valid  (data_wr),
		.in_ready  (),
		.in_data   (sfr_wdata),
		.out_valid (tx_byte_valid),
		.out_ready (tx_byte_ready),
		.out_data  (tx_byte),
		.count     (txq_count)
	);

	// Overflow: both buffers full and the receiver still offers a byte.
	// Only the first lost byte counts; the sticky flag hides the rest,
	// so one overflow raises the error cause for one cycle.
	assign overflow_event = rx_byte_valid & ~rx_byte_ready
		& ~rxq_in_ready & ~rx_overflow;

	// Gathers the eight source conditions at their bit positions.
	always_comb begin
		cond_now = '0;
		cond_now[rfiq_pkg::BIT_REG_ON] = regulator_on;
		cond_now[rfiq_pkg::BIT_TX_DONE] = transmit_done
			| (ack_sent & ack_source_select);
		cond_now[rfiq_pkg::BIT_RX_THR] = receive_threshold_status;
		cond_now[rfiq_pkg::BIT_FRAME] = frame_start;
		cond_now[rfiq_pkg::BIT_CHAN_CLR] = channel_clear;
		cond_now[rfiq_pkg::BIT_SEQ_WAIT] = sequencer_wait;
		cond_now[rfiq_pkg::BIT_SEQ_HALT] = sequencer_halt;
		cond_now[rfiq_pkg::BIT_SEQ_INSTR] = sequencer_instr;
	end

	// Each flag sets on a rising condition whatever its mask says.
	// A bus write of 0 clears it, of 1 keeps it; a set wins.
	// A set in the cycle of a clearing write survives, so an event that
	// lands between a handler's read and its write-back is not lost.
	for (genvar i = 0; i < rfiq_pkg::NUM_SRC; i++) begin : g_flag
		assign next_flags[i] = (cond_now[i] & ~cond_prev[i])
			| (radio_source_flag_reg[i]
			& (~flag_wr | sfr_wdata[i]));
	end

	// Mask register update.
	always_comb begin
		next_mask = radio_source_mask_reg;
		if (mask_wr) begin
			next_mask = sfr_wdata;
		end
	end

	// The event request is high while any enabled flag stays set.
	// As a level it sets the vector pending flag again after a clear,
	// so a source left flagged is served once more.
	assign event_req = |(radio_source_flag_reg
		& radio_source_mask_reg);

	// Error cause: transmit underflow or receive overflow, nothing else.
	assign error_event = transmit_underflow | overflow_event;

	// Vector pending flags; a new cause wins over a clear.
	// A clear that meets a new cause is ignored, so no request is lost.
	// The overflow flag is sticky until the receive flush strobe.
	always_comb begin
		next_err_pend = error_event
			| (error_vector_pending & ~error_pending_clear);
		next_evt_pend = event_req
			| (event_vector_pending & ~event_pending_clear);
		next_overflow = overflow_event
			| (rx_overflow & ~receive_flush_strobe);
	end

	// Receive status from the receive queue count; data present also needs no overflow.
	// Data present falls during an overflow, so software sees the fault
	// even while older bytes can still be read.
	always_comb begin
		next_thr_status = rxq_count
			> {1'b0, receive_threshold_level};
		next_present = (rxq_count != '0) & ~next_overflow;
	end

	// Bus read data; a read of the data port pops the receive queue.
	// The data is zero outside a read, so a byte shown for one cycle is
	// never taken for a second pop.
	always_comb begin
		next_rdata = rfiq_pkg::RDATA_RESET;
		if (sfr_rd) begin
			unique case (sfr_addr)
				rfiq_pkg::ADDR_MASK: begin
					next_rdata = radio_source_mask_reg;
				end
				rfiq_pkg::ADDR_FLAGS: begin
					next_rdata = radio_source_flag_reg;
				end
				rfiq_pkg::ADDR_DATA: begin
					// An empty queue reads as zero.
					next_rdata = rxq_out_valid ? rxq_out_data
						: rfiq_pkg::RDATA_RESET;
				end
				default: begin
					next_rdata = rfiq_pkg::RDATA_RESET;
				end
			endcase
		end
	end

	// Registers flags, mask, status, requests and read data.
	// Every CPU-side output is taken straight from a register here, so nothing
	// on the CPU side sees a combinational path from the radio.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			radio_source_flag_reg    <= rfiq_pkg::FLAGS_RESET;
			radio_source_mask_reg    <= rfiq_pkg::MASK_RESET;
			cond_prev                <= '0;
			rx_overflow              <= 1'b0;
			error_vector_pending     <= 1'b0;
			event_vector_pending     <= 1'b0;
			radio_error_request      <= 1'b0;
			radio_event_request      <= 1'b0;
			receive_threshold_status <= 1'b0;
			receive_data_present     <= 1'b0;
			sfr_rdata                <= rfiq_pkg::RDATA_RESET;
		end else begin
			radio_source_flag_reg    <= next_flags;
			radio_source_mask_reg    <= next_mask;
			cond_prev                <= cond_now;
			rx_overflow              <= next_overflow;
			error_vector_pending     <= next_err_pend;
			event_vector_pending     <= next_evt_pend;
			// Each request needs its pending flag and vector enable.
			radio_error_request      <= next_err_pend
				& error_vector_enable;
			radio_event_request      <= next_evt_pend
				& event_vector_enable;
			receive_threshold_status <= next_thr_status;
			receive_data_present     <= next_present;
			sfr_rdata                <= next_rdata;
		end
	end

endmodule : rfiq_top
`default_nettype wire

// File: sim/rfiq_radio_model.sv
// Radio byte source and byte sink on the far side of the block.
// Assumes the bench sets a byte quota and a sink stall.
`timescale 1ns/1ps
`default_nettype none
module rfiq_radio_model (
	// Clock, reset and bench controls.
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [7:0] quota,
	input  wire logic       stall,
	// Byte source into the block.
	output var  logic       rx_byte_valid,
	input  wire logic       rx_byte_ready,
	output var  logic [7:0] rx_byte,
	// Byte sink out of the block.
	input  wire logic       tx_byte_valid,
	output var  logic       tx_byte_ready,
	input  wire logic [7:0] tx_byte
);
	logic [7:0] n_sent;     // Bytes taken by the block.
	logic [7:0] n_got;      // Bytes taken from the block.
	logic [7:0] got [0:15]; // Captured transmit bytes.
	// Offers until the quota is met; idle data is the last byte inverted.
	assign rx_byte_valid = (n_sent < quota);
	assign rx_byte = rx_byte_valid ? 8'hA0 + n_sent : ~(8'h9F + n_sent);
	assign tx_byte_ready = !stall;
	// Counts the transfers of both streams and keeps the transmit bytes.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			n_sent <= 8'h00;
			n_got  <= 8'h00;
		end else begin
			n_sent <= n_sent + 8'(rx_byte_valid && rx_byte_ready);
			if (tx_byte_valid && tx_byte_ready) begin
				got[n_got[3:0]] <= tx_byte;
				n_got <= n_got + 8'h01;
			end
		end
	end
endmodule : rfiq_radio_model
`default_nettype wire

// File: sim/rfiq_monitor.sv
// Concurrent checks on the ports of the radio interrupt block.
// Assumes it is bound into rfiq_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rfiq_monitor (
	// Clock, reset and read side of the register bus.
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	// Vector enables, pending flags and requests.
	input wire logic       error_vector_enable,
	input wire logic       event_vector_enable,
	input wire logic       error_vector_pending,
	input wire logic       event_vector_pending,
	input wire logic       radio_error_request,
	input wire logic       radio_event_request,
	// Error cause, flushes and receive status.
	input wire logic       transmit_underflow,
	input wire logic       receive_flush_strobe,
	input wire logic       transmit_flush_strobe,
	input wire logic       receive_data_present,
	input wire logic       receive_threshold_status,
	// Both byte streams.
	input wire logic       rx_byte_valid,
	input wire logic       rx_byte_ready,
	input wire logic       tx_byte_valid,
	input wire logic       tx_byte_ready,
	input wire logic [7:0] tx_byte
);
	logic mapped; // High for the three register addresses.
	assign mapped = sfr_addr inside {rfiq_pkg::ADDR_MASK,
		rfiq_pkg::ADDR_DATA, rfiq_pkg::ADDR_FLAGS};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Underflow seen while the error vector is enabled.
	sequence s_uflow;
		transmit_underflow && error_vector_enable;
	endsequence
	// Error vector both pending and requested.
	sequence s_err_up;
		error_vector_pending && radio_error_request;
	endsequence
	a_uflow_raises_err: assert property (s_uflow |=> s_err_up)
		else $error("Underflow did not raise the error request.");
	a_err_has_cause: assert property ($rose(error_vector_pending) |->
		$past(transmit_underflow || (rx_byte_valid && !rx_byte_ready)))
		else $error("Error pending rose without a queue fault.");
	a_err_needs_en: assert property (!error_vector_enable |=>
		!radio_error_request)
		else $error("Error request while its vector was disabled.");
	a_evt_needs_en: assert property (!event_vector_enable |=>
		!radio_event_request)
		else $error("Event request while its vector was disabled.");
	a_evt_req_pend: assert property (radio_event_request |->
		event_vector_pending)
		else $error("Event request without its pending flag.");
	a_rdata_idle_zero: assert property ((!sfr_rd || !mapped) |=>
		sfr_rdata == 8'h00)
		else $error("Read data not zero outside a mapped read.");
	a_tx_byte_held: assert property (tx_byte_valid && !tx_byte_ready &&
		!transmit_flush_strobe |=> tx_byte_valid && $stable(tx_byte))
		else $error("Transmit byte changed while stalled.");
	a_rx_flush_empty: assert property (receive_flush_strobe |->
		##[1:3] !receive_data_present && !receive_threshold_status)
		else $error("Receive flush left the receive status up.");
endmodule : rfiq_monitor
bind rfiq_top rfiq_monitor u_mon (.sys_clk, .rst, .sfr_addr, .sfr_rd,
	.sfr_rdata, .error_vector_enable, .event_vector_enable,
	.error_vector_pending, .event_vector_pending, .radio_error_request,
	.radio_event_request, .transmit_underflow, .receive_flush_strobe,
	.transmit_flush_strobe, .receive_data_present,
	.receive_threshold_status, .rx_byte_valid, .rx_byte_ready,
	.tx_byte_valid, .tx_byte_ready, .tx_byte);
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the radio interrupt and queue port block.
// Assumes the radio model and the bound monitor beside the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Pulse codes: underflow, error clear, event clear, flushes.
	localparam logic [4:0] UFLOW = 5'h10, ERR_CLR = 5'h08, EVT_CLR = 5'h04;
	localparam logic [4:0] TX_FL = 5'h02, RX_FL = 5'h01;
	// Bytes sent when the receive side first overflows: eight earlier
	// bytes, then the receive queue and the staging buffer filled.
	localparam int FILL = 8 + rfiq_pkg::QUEUE_DEPTH + rfiq_pkg::STAGE_DEPTH;
	logic       sys_clk, rst, sfr_wr, sfr_rd, stall;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val, quota, vec, conds;
	logic       error_vector_enable, event_vector_enable;
	logic       error_pending_clear, event_pending_clear;
	logic       error_vector_pending, event_vector_pending;
	logic       radio_error_request, radio_event_request, ack_sent;
	logic       regulator_on, transmit_done, ack_source_select;
	logic       frame_start, channel_clear, sequencer_wait;
	logic       sequencer_halt, sequencer_instr, transmit_underflow;
	logic [6:0] receive_threshold_level;
	logic       receive_data_present, receive_threshold_status;
	logic       transmit_flush_strobe, receive_flush_strobe;
	logic       rx_byte_valid, rx_byte_ready, tx_byte_valid, tx_byte_ready;
	logic [7:0] rx_byte, tx_byte;
	logic [4:0] pls; // One-cycle strobes, coded as above.
	int         n_fail, comparisons, i;
	assign {regulator_on, transmit_done} = conds[7:6];
	assign {frame_start, channel_clear, sequencer_wait, sequencer_halt,
		sequencer_instr} = conds[4:0];
	assign {transmit_underflow, error_pending_clear, event_pending_clear,
		transmit_flush_strobe, receive_flush_strobe} = pls;
	// Status byte: data, threshold, error pend/req, event pend/req.
	assign vec = {2'h0, receive_data_present, receive_threshold_status,
		error_vector_pending, radio_error_request, event_vector_pending,
		radio_event_request};
	rfiq_top dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .error_vector_enable, .event_vector_enable,
		.error_pending_clear, .event_pending_clear, .error_vector_pending,
		.event_vector_pending, .radio_error_request, .radio_event_request,
		.regulator_on, .transmit_done, .ack_sent, .ack_source_select,
		.frame_start, .channel_clear, .sequencer_wait, .sequencer_halt,
		.sequencer_instr, .transmit_underflow, .receive_threshold_level,
		.receive_data_present, .receive_threshold_status,
		.transmit_flush_strobe, .receive_flush_strobe, .rx_byte_valid,
		.rx_byte_ready, .rx_byte, .tx_byte_valid, .tx_byte_ready, .tx_byte);
	rfiq_radio_model m (.sys_clk, .rst, .quota, .stall, .rx_byte_valid,
		.rx_byte_ready, .rx_byte, .tx_byte_valid, .tx_byte_ready, .tx_byte);
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// Compares one byte result and counts it.
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One register write: strobe for exactly one cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge sys_clk);
		sfr_wr    <= 1'b0;
	endtask : wr
	// One register read; data is taken the cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge sys_clk);
		sfr_rd   <= 1'b0;
		#1 rd_val = sfr_rdata;
	endtask : rd
	// Raises the coded strobes for one cycle, then lets results settle.
	task automatic pulse(input logic [4:0] p);
		@(posedge sys_clk) pls <= p;
		@(posedge sys_clk) pls <= 5'h00;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : pulse
	// Waits for a status bit under a bound; running out ends the run.
	task automatic wait_hi(input int b);
		int k;
		#1;
		for (k = 0; k < 400 && vec[b] !== 1'b1; k++) #5;
		if (vec[b] !== 1'b1) begin
			n_fail++;
			conclude();
		end
	endtask : wait_hi
	// Free-running 200 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Main sequence of scenarios.
	initial begin
		{sfr_wr, sfr_rd, error_vector_enable, event_vector_enable} = 4'h0;
		{ack_sent, ack_source_select, stall, pls} = 8'h00;
		{sfr_addr, sfr_wdata, conds, quota} = 32'h0;
		receive_threshold_level = 7'h02;
		n_fail = 0;
		comparisons = 0;
		rst = 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(rfiq_pkg::ADDR_MASK);
		chk("mask reset", 8'h00, rd_val);
		rd(rfiq_pkg::ADDR_FLAGS);
		chk("flag reset", 8'h00, rd_val);
		wr(8'h55, 8'hFF);
		rd(8'h55);
		chk("unmapped", 8'h00, rd_val);
		wr(rfiq_pkg::ADDR_MASK, 8'hFF);
		rd(rfiq_pkg::ADDR_MASK);
		chk("mask rw", 8'hFF, rd_val);
		error_vector_enable <= 1'b1;
		event_vector_enable <= 1'b1;
		// Each edge source in turn; the threshold source comes later.
		for (i = 0; i < 8; i++) begin
			if (i == 5) continue;
			@(posedge sys_clk) conds[i] <= 1'b1;
			wait_hi(0);
			rd(rfiq_pkg::ADDR_FLAGS);
			chk("flag", 8'(1 << i), rd_val);
			pulse(EVT_CLR);
			chk("requeue", 8'h03, vec);
			wr(rfiq_pkg::ADDR_FLAGS, 8'h00);
			pulse(EVT_CLR);
			rd(rfiq_pkg::ADDR_FLAGS);
			chk("level held", 8'h00, rd_val);
			chk("retired", 8'h00, vec);
			conds[i] <= 1'b0;
		end
		// Masked source still flags; then two-level enabling.
		wr(rfiq_pkg::ADDR_MASK, 8'h00);
		@(posedge sys_clk) conds[3] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		wr(rfiq_pkg::ADDR_FLAGS, 8'hFF);
		rd(rfiq_pkg::ADDR_FLAGS);
		chk("masked flag", 8'h08, rd_val);
		chk("masked req", 8'h00, vec);
		event_vector_enable <= 1'b0;
		wr(rfiq_pkg::ADDR_MASK, 8'h08);
		pulse(5'h00);
		chk("vector off", 8'h02, vec);
		event_vector_enable <= 1'b1;
		wait_hi(0);
		chk("vector on", 8'h03, vec);
		conds[3] <= 1'b0;
		wr(rfiq_pkg::ADDR_FLAGS, 8'h00);
		pulse(EVT_CLR);
		// Sent acknowledge feeds the transmit flag only when selected.
		for (i = 0; i < 2; i++) begin
			ack_source_select <= i[0];
			@(posedge sys_clk) ack_sent <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ack_sent <= 1'b0;
			rd(rfiq_pkg::ADDR_FLAGS);
			chk("ack", {1'b0, i[0], 6'h00}, rd_val);
			wr(rfiq_pkg::ADDR_FLAGS, 8'h00);
		end
		// Stalled transmit bytes are flushed; later ones arrive in order.
		stall <= 1'b1;
		wr(rfiq_pkg::ADDR_DATA, 8'h11);
		wr(rfiq_pkg::ADDR_DATA, 8'h22);
		pulse(TX_FL);
		chk("rx untouched", 8'h00, vec & 8'h30);
		stall <= 1'b0;
		wr(rfiq_pkg::ADDR_DATA, 8'h5A);
		wr(rfiq_pkg::ADDR_DATA, 8'hC3);
		pulse(5'h00);
		chk("tx count", 8'h02, m.n_got);
		chk("tx first", 8'h5A, m.got[0]);
		chk("tx second", 8'hC3, m.got[1]);
		// Three received bytes pass a threshold of two.
		quota <= 8'd3;
		wait_hi(4);
		chk("rx status", 8'h30, vec & 8'h30);
		rd(rfiq_pkg::ADDR_FLAGS);
		chk("thr flag", 8'h20, rd_val & 8'h20);
		for (i = 0; i < 3; i++) begin
			rd(rfiq_pkg::ADDR_DATA);
			chk("rx data", 8'hA0 + 8'(i), rd_val);
		end
		rd(rfiq_pkg::ADDR_DATA);
		chk("rx empty", 8'h00, rd_val);
		chk("rx drained", 8'h00, vec & 8'h30);
		// Five more bytes, then a receive flush.
		quota <= 8'd8;
		repeat (20) @(posedge sys_clk);
		pulse(RX_FL);
		rd(rfiq_pkg::ADDR_DATA);
		chk("rx flushed", 8'h00, rd_val);
		// Underflow raises and clears the error vector.
		pulse(UFLOW);
		chk("underflow", 8'h0C, vec & 8'h0C);
		pulse(ERR_CLR);
		chk("err clear", 8'h00, vec & 8'h0C);
		// Fill the receive side until it overflows; count bytes at the error.
		quota <= 8'd150;
		wait_hi(3);
		chk("fill", 8'(FILL), m.n_sent);
		repeat (40) @(posedge sys_clk);
		#1 chk("overflow", 8'h0C, vec & 8'h2C);
		// Only a receive flush lets new bytes into the queue again.
		pulse(RX_FL);
		quota <= 8'd151;
		wait_hi(5);
		rd(rfiq_pkg::ADDR_DATA);
		chk("after flush", 8'hA0 + 8'd150, rd_val);
		conclude();
	end
endmodule : testbench
`default_nettype wire
